// >>> verilog/sdc_pkg.sv
// package for the segment descriptor checker: field positions, type codes,
// exception vectors and the packed carriers shared by the checker and its cache.
// assumes the descriptor fetch and the stack copy are done by the execution unit.
package sdc_pkg;
  // access byte field positions
  localparam int unsigned ACC_PRESENT = 7;
  localparam int unsigned ACC_DPL_HI = 6;
  localparam int unsigned ACC_DPL_LO = 5;
  localparam int unsigned ACC_SEG = 4;
  localparam int unsigned ACC_EXEC = 3;
  localparam int unsigned ACC_DIR = 2; // grow_down_flag or conforming
  localparam int unsigned ACC_RW = 1; // writable or readable
  localparam int unsigned ACC_ACCESSED = 0;
  localparam int unsigned TYPE_HI = 3;
  // selector fields
  localparam int unsigned SEL_TABLE = 2;
  localparam int unsigned SEL_IDX_LO = 3;
  localparam int unsigned IDX_W = 13;
  localparam int unsigned DESC_SHIFT = 3; // eight bytes per descriptor
  localparam int unsigned DESC_LAST = 7; // offset of a descriptor's last byte
  localparam int unsigned WC_W = 5;
  // system and gate type codes
  localparam logic [3:0] TYP_INVALID0 = 4'h0;
  localparam logic [3:0] TYP_TSS_AVAIL = 4'h1;
  localparam logic [3:0] TYP_LOCAL_TAB = 4'h2;
  localparam logic [3:0] TYP_TSS_BUSY = 4'h3;
  localparam logic [3:0] TYP_CALL_GATE = 4'h4;
  localparam logic [3:0] TYP_TASK_GATE = 4'h5;
  localparam logic [3:0] TYP_INT_GATE = 4'h6;
  localparam logic [3:0] TYP_TRAP_GATE = 4'h7;
  localparam logic [3:0] TYP_INVALID8 = 4'h8;
  // exception vectors
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_NOT_PRESENT = 8'h0b;
  localparam logic [7:0] EXC_PROTECT = 8'h0d;
  // privilege
  localparam logic [1:0] PRIV_TOP = 2'h0;
  // table reset values
  localparam logic [23:0] TAB_BASE_RST = 24'h000000;
  localparam logic [15:0] TAB_LIMIT_RST = 16'h0000;
  localparam logic [15:0] INT_LIMIT_RST = 16'h03ff;
  // segment register index
  localparam logic [1:0] SEG_CODE = 2'h0;
  localparam logic [1:0] SEG_STACK = 2'h1;
  localparam logic [1:0] SEG_DATA = 2'h2;
  localparam logic [1:0] SEG_EXTRA = 2'h3;

  // requests from the execution unit
  typedef enum logic [2:0] {
    SDC_OP_NONE, SDC_OP_LOAD_SEG, SDC_OP_TEST_SEL, SDC_OP_GATE,
    SDC_OP_LOAD_GLOBAL, SDC_OP_LOAD_LOCAL, SDC_OP_LOAD_INT, SDC_OP_ACCESS
  } sdc_op_t;

  // gate kinds decoded from the type field
  typedef enum logic [2:0] {
    SDC_GATE_NONE, SDC_GATE_CALL, SDC_GATE_TASK, SDC_GATE_INT, SDC_GATE_TRAP
  } sdc_gate_t;

  // one descriptor as fetched from memory
  typedef struct packed {
    logic [7:0] access;
    logic [23:0] base;
    logic [15:0] limit; // limit, or destination offset for a gate
    logic [15:0] dest_sel; // gate destination selector
    logic [4:0] word_count; // gate parameter word count
  } sdc_desc_t;

  // base and limit of a descriptor table
  typedef struct packed {
    logic [23:0] base;
    logic [15:0] limit;
  } sdc_table_t;

  // one hidden cache entry
  typedef struct packed {
    logic valid;
    logic [15:0] selector;
    logic [7:0] access;
    logic [23:0] base;
    logic [15:0] limit;
  } sdc_cache_t;
endpackage

// >>> verilog/sdc_seg_cache.sv
// hidden descriptor caches of the four segment registers.
// assumes the checker only asserts a write once the descriptor passed its checks.
`timescale 1ns/1ns
`default_nettype none
module sdc_seg_cache #(
  parameter int unsigned NSEG = 4
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic [1:0] wr_idx,
  input wire sdc_pkg::sdc_cache_t wr_entry,
  output sdc_pkg::sdc_cache_t entries [NSEG]
);
  // one entry per segment register, held in flip-flops
  sdc_pkg::sdc_cache_t ent_q [NSEG];
  sdc_pkg::sdc_cache_t ent_d [NSEG];

  // load on register load
  // next value: only the addressed entry changes; nothing reads it back out to software
  always_comb begin
    for (int i = 0; i < NSEG; i++) begin
      ent_d[i] = ent_q[i];
      if (wr_en && (wr_idx == 2'(i))) begin
        ent_d[i] = wr_entry;
      end
    end
  end

  // registers, cleared to invalid
  generate
    for (genvar g = 0; g < NSEG; g++) begin : g_ent
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          ent_q[g] <= '0;
        end else begin
          ent_q[g] <= ent_d[g];
        end
      end
      assign entries[g] = ent_q[g];
    end
  endgenerate

  // a write lands in the addressed entry next cycle
  property p_cache_load;
    @(posedge clock) disable iff (!rst_b)
    wr_en |=> (entries[$past(wr_idx)] == $past(wr_entry));
  endproperty
  a_cache_load: assert property (p_cache_load) else $error("cache entry not loaded");
endmodule
`default_nettype wire

// >>> verilog/sdc_checker.sv
// segment descriptor checker: decodes fetched descriptors, validates table
// references, loads the hidden caches and reports exceptions.
// assumes the execution unit fetches the descriptor at desc_addr and presents
// it in the same cycle as the request, so desc_addr is served combinationally.
//
// Operation
// - access bit 4 marks code/data descriptors
// - grow-down data inverts the limit test
// - clear writable bit blocks data writes
// - execute-only code blocks reads; code unwritable
// - conforming code runs when current level numerically higher or equal
// - set accessed bit on load or test
// - decode system type codes
// - not-present gate raises exception 11
// - decode call, task, interrupt, trap gates
// - interrupt gate clears interrupt enable
// - gate target type mismatch raises 13
// - call gate word count on privilege change
// - task gate ignores destination offset
// - four hidden caches loaded on register load
// - only code/data enter a cache
// - upper 13 selector bits index tables
// - beyond table limit raises 13
// - table content type restrictions enforced
// - table loads only at level 0; the interrupt table load has no level check
// - global/interrupt load six bytes, local selector
// - interrupt table holds gates, 256 vectors
// - four privilege levels, zero most privileged
// - requested_priv from selector low bits
// - current_priv_level from code selector low bits
`timescale 1ns/1ns
`default_nettype none
module sdc_checker #(
  parameter int unsigned NSEG = 4
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic req_valid, // one-cycle request strobe
  input wire sdc_pkg::sdc_op_t req_op,
  input wire logic [1:0] req_seg, // target segment register
  input wire logic [15:0] req_sel, // selector being used
  input wire logic [7:0] req_vector, // interrupt vector for gate use
  input wire logic req_from_int, // gate reached through the interrupt table
  input wire logic req_write, // data access is a write
  input wire logic req_exec, // access is an instruction fetch
  input wire logic [15:0] req_offset, // offset of a data access
  input wire logic priv_change, // call gate transfer changes level
  input wire sdc_pkg::sdc_desc_t req_desc, // fetched descriptor
  input wire sdc_pkg::sdc_desc_t gate_target, // descriptor named by a gate
  input wire sdc_pkg::sdc_table_t req_table, // six-byte operand
  input wire logic if_in, // interrupt enable before gate entry
  output logic [23:0] desc_addr, // physical address of the referenced entry
  output logic done, // result valid, one cycle
  output logic [7:0] exc_vector, // exception raised, zero if none
  output logic [7:0] accessed_access, // access byte with accessed bit set
  output logic accessed_wr, // write accessed_access back to memory
  output logic if_out, // interrupt enable after gate entry
  output logic [4:0] copy_words, // parameter words to copy
  output logic [15:0] target_sel, // destination selector of a gate
  output logic [15:0] target_offset, // entry point of a gate
  output sdc_pkg::sdc_gate_t gate_kind,
  output logic [1:0] current_priv_level,
  output sdc_pkg::sdc_table_t global_table,
  output sdc_pkg::sdc_table_t local_table,
  output sdc_pkg::sdc_table_t interrupt_table
);
  // decoded request fields
  logic [1:0] requested_priv;
  logic table_select;
  logic [12:0] desc_index;
  logic [15:0] desc_off;
  logic [7:0] acc;
  logic is_seg, is_code, present;
  logic [1:0] descriptor_priv_level;
  logic [3:0] sys_type;
  sdc_pkg::sdc_table_t ref_table;
  // cache wiring
  logic cache_wr;
  sdc_pkg::sdc_cache_t cache_entry;
  sdc_pkg::sdc_cache_t cache [NSEG];
  // result registers
  logic done_q, done_d;
  logic [7:0] exc_q, exc_d;
  logic [7:0] accb_q, accb_d;
  logic accw_q, accw_d;
  logic if_q, if_d;
  logic [4:0] wc_q, wc_d;
  logic [15:0] tsel_q, tsel_d, toff_q, toff_d;
  sdc_pkg::sdc_gate_t gk_q, gk_d;
  sdc_pkg::sdc_table_t gt_q, gt_d, lt_q, lt_d, it_q, it_d;

  assign requested_priv = req_sel[1:0];
  assign table_select = req_sel[sdc_pkg::SEL_TABLE];
  assign desc_index = req_sel[15:sdc_pkg::SEL_IDX_LO];
  assign acc = req_desc.access;
  assign is_seg = acc[sdc_pkg::ACC_SEG];
  assign is_code = acc[sdc_pkg::ACC_EXEC];
  assign present = acc[sdc_pkg::ACC_PRESENT];
  assign descriptor_priv_level = acc[sdc_pkg::ACC_DPL_HI:sdc_pkg::ACC_DPL_LO];
  assign sys_type = acc[sdc_pkg::TYPE_HI:0];
  assign current_priv_level = cache[sdc_pkg::SEG_CODE].selector[1:0];

  // table and address of the entry being referenced; interrupt uses the vector
  always_comb begin
    desc_off = 16'(desc_index) << sdc_pkg::DESC_SHIFT;
    ref_table = table_select ? lt_q : gt_q;
    if (req_op == sdc_pkg::SDC_OP_GATE && req_from_int) begin
      ref_table = it_q;
      desc_off = 16'(req_vector) << sdc_pkg::DESC_SHIFT;
    end
    desc_addr = ref_table.base + 24'(desc_off);
  end

  // the hidden caches
  sdc_seg_cache #(.NSEG(NSEG)) u_cache (
    .clock(clock),
    .rst_b(rst_b),
    .wr_en(cache_wr),
    .wr_idx(req_seg),
    .wr_entry(cache_entry),
    .entries(cache)
  );

  // next values of every result and table register
  always_comb begin
    logic over;
    logic [15:0] lim;
    over = 1'b0;
    lim = 16'h0000;
    done_d = req_valid;
    exc_d = sdc_pkg::EXC_NONE;
    accb_d = accb_q;
    accw_d = 1'b0;
    if_d = if_in;
    wc_d = '0;
    tsel_d = tsel_q;
    toff_d = toff_q;
    gk_d = sdc_pkg::SDC_GATE_NONE;
    gt_d = gt_q;
    lt_d = lt_q;
    it_d = it_q;
    cache_wr = 1'b0;
    cache_entry = '{valid: 1'b1, selector: req_sel,
                    access: acc | (8'h01 << sdc_pkg::ACC_ACCESSED),
                    base: req_desc.base, limit: req_desc.limit};
    over = (32'(desc_off) + 32'(sdc_pkg::DESC_LAST)) > 32'(ref_table.limit);
    if (req_valid) begin
      case (req_op)
        sdc_pkg::SDC_OP_LOAD_SEG, sdc_pkg::SDC_OP_TEST_SEL: begin
          if (over) begin
            exc_d = sdc_pkg::EXC_PROTECT;
          end else if (!is_seg) begin
            exc_d = sdc_pkg::EXC_PROTECT;
          end else if (!present) begin
            exc_d = sdc_pkg::EXC_NOT_PRESENT;
          end else begin
            accb_d = acc | (8'h01 << sdc_pkg::ACC_ACCESSED);
            accw_d = 1'b1;
            cache_wr = (req_op == sdc_pkg::SDC_OP_LOAD_SEG);
          end
        end
        sdc_pkg::SDC_OP_GATE: begin
          if (over) begin
            exc_d = sdc_pkg::EXC_PROTECT;
          end else if (is_seg || sys_type < sdc_pkg::TYP_CALL_GATE
                       || sys_type > sdc_pkg::TYP_TRAP_GATE) begin
            exc_d = sdc_pkg::EXC_PROTECT;
          end else if (req_from_int && sys_type == sdc_pkg::TYP_CALL_GATE) begin
            exc_d = sdc_pkg::EXC_PROTECT;
          end else if (!req_from_int && !table_select
                       && sys_type >= sdc_pkg::TYP_INT_GATE) begin
            exc_d = sdc_pkg::EXC_PROTECT;
          end else if (!req_from_int && table_select
                       && sys_type >= sdc_pkg::TYP_INT_GATE) begin
            exc_d = sdc_pkg::EXC_PROTECT;
          end else if (!present) begin
            exc_d = sdc_pkg::EXC_NOT_PRESENT;
          end else begin
            tsel_d = req_desc.dest_sel;
            case (sys_type)
              sdc_pkg::TYP_CALL_GATE: gk_d = sdc_pkg::SDC_GATE_CALL;
              sdc_pkg::TYP_TASK_GATE: gk_d = sdc_pkg::SDC_GATE_TASK;
              sdc_pkg::TYP_INT_GATE: gk_d = sdc_pkg::SDC_GATE_INT;
              default: gk_d = sdc_pkg::SDC_GATE_TRAP;
            endcase
            if (sys_type == sdc_pkg::TYP_TASK_GATE) begin
              toff_d = 16'h0000;
              // task gate needs a task segment
              if (gate_target.access[sdc_pkg::ACC_SEG]
                  || (gate_target.access[sdc_pkg::TYPE_HI:0] != sdc_pkg::TYP_TSS_AVAIL
                      && gate_target.access[sdc_pkg::TYPE_HI:0] != sdc_pkg::TYP_TSS_BUSY)) begin
                exc_d = sdc_pkg::EXC_PROTECT;
              end
            end else begin
              toff_d = req_desc.limit;
              if (!gate_target.access[sdc_pkg::ACC_SEG]
                  || !gate_target.access[sdc_pkg::ACC_EXEC]) begin
                exc_d = sdc_pkg::EXC_PROTECT;
              end
            end
            if (sys_type == sdc_pkg::TYP_CALL_GATE && priv_change) begin
              wc_d = req_desc.word_count;
            end
            if (sys_type == sdc_pkg::TYP_INT_GATE && exc_d == sdc_pkg::EXC_NONE) begin
              if_d = 1'b0;
            end
          end
        end
        sdc_pkg::SDC_OP_LOAD_GLOBAL: begin
          if (current_priv_level != sdc_pkg::PRIV_TOP) begin
            exc_d = sdc_pkg::EXC_PROTECT;
          end else begin
            gt_d = req_table;
          end
        end
        sdc_pkg::SDC_OP_LOAD_INT: begin
          it_d = req_table;
        end
        sdc_pkg::SDC_OP_LOAD_LOCAL: begin
          if (current_priv_level != sdc_pkg::PRIV_TOP) begin
            exc_d = sdc_pkg::EXC_PROTECT;
          end else if (over || table_select || is_seg
                       || sys_type != sdc_pkg::TYP_LOCAL_TAB) begin
            exc_d = sdc_pkg::EXC_PROTECT;
          end else if (!present) begin
            exc_d = sdc_pkg::EXC_NOT_PRESENT;
          end else begin
            lt_d = '{base: req_desc.base, limit: req_desc.limit};
          end
        end
        sdc_pkg::SDC_OP_ACCESS: begin
          // checks against the cached descriptor of the chosen register
          lim = cache[req_seg].limit;
          if (!cache[req_seg].valid) begin
            exc_d = sdc_pkg::EXC_PROTECT;
          end else if (cache[req_seg].access[sdc_pkg::ACC_EXEC]) begin
            if (req_write || (!req_exec && !cache[req_seg].access[sdc_pkg::ACC_RW])) begin
              exc_d = sdc_pkg::EXC_PROTECT;
            // conforming needs current level >= descriptor level
            end else if (req_exec && cache[req_seg].access[sdc_pkg::ACC_DIR]
                         && current_priv_level
                          < cache[req_seg].access[sdc_pkg::ACC_DPL_HI:sdc_pkg::ACC_DPL_LO]) begin
              exc_d = sdc_pkg::EXC_PROTECT;
            end else if (req_offset > lim) begin
              exc_d = sdc_pkg::EXC_PROTECT;
            end
          end else begin
            if (req_exec || (req_write && !cache[req_seg].access[sdc_pkg::ACC_RW])) begin
              exc_d = sdc_pkg::EXC_PROTECT;
            end else if (cache[req_seg].access[sdc_pkg::ACC_DIR] ? (req_offset <= lim)
                         : (req_offset > lim)) begin
              exc_d = sdc_pkg::EXC_PROTECT;
            end
          end
        end
        default: begin
          done_d = 1'b0;
        end
      endcase
    end
    if (exc_d != sdc_pkg::EXC_NONE) begin
      cache_wr = 1'b0;
    end
  end

  // result and table registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      done_q <= 1'b0;
      exc_q <= sdc_pkg::EXC_NONE;
      accb_q <= 8'h00;
      accw_q <= 1'b0;
      if_q <= 1'b0;
      wc_q <= '0;
      tsel_q <= 16'h0000;
      toff_q <= 16'h0000;
      gk_q <= sdc_pkg::SDC_GATE_NONE;
      gt_q <= '{base: sdc_pkg::TAB_BASE_RST, limit: sdc_pkg::TAB_LIMIT_RST};
      lt_q <= '{base: sdc_pkg::TAB_BASE_RST, limit: sdc_pkg::TAB_LIMIT_RST};
      it_q <= '{base: sdc_pkg::TAB_BASE_RST, limit: sdc_pkg::INT_LIMIT_RST};
    end else begin
      done_q <= done_d;
      exc_q <= exc_d;
      accb_q <= accb_d;
      accw_q <= accw_d;
      if_q <= if_d;
      wc_q <= wc_d;
      tsel_q <= tsel_d;
      toff_q <= toff_d;
      gk_q <= gk_d;
      gt_q <= gt_d;
      lt_q <= lt_d;
      it_q <= it_d;
    end
  end

  assign done = done_q;
  assign exc_vector = exc_q;
  assign accessed_access = accb_q;
  assign accessed_wr = accw_q;
  assign if_out = if_q;
  assign copy_words = wc_q;
  assign target_sel = tsel_q;
  assign target_offset = toff_q;
  assign gate_kind = gk_q;
  assign global_table = gt_q;
  assign local_table = lt_q;
  assign interrupt_table = it_q;

  // limit overrun as the decode sees it, declared before the checks use it
  logic over_w;
  assign over_w = (32'(desc_off) + 32'(sdc_pkg::DESC_LAST)) > 32'(ref_table.limit);

  // a system descriptor loaded into a register faults and never fills a cache
  property p_sys_not_cached;
    @(posedge clock) disable iff (!rst_b)
    (req_valid && req_op == sdc_pkg::SDC_OP_LOAD_SEG && !is_seg)
      |-> !cache_wr ##1 exc_vector == sdc_pkg::EXC_PROTECT;
  endproperty
  a_sys_not_cached: assert property (p_sys_not_cached) else $error("system desc cached");

  property p_not_present;
    @(posedge clock) disable iff (!rst_b)
    (req_valid && req_op == sdc_pkg::SDC_OP_LOAD_SEG && is_seg && !present && !over_w)
      |-> !cache_wr ##1 exc_vector == sdc_pkg::EXC_NOT_PRESENT;
  endproperty
  a_not_present: assert property (p_not_present) else $error("not-present missed");

  property p_limit;
    @(posedge clock) disable iff (!rst_b)
    (req_valid && req_op == sdc_pkg::SDC_OP_LOAD_SEG && over_w)
      |=> done && exc_vector == sdc_pkg::EXC_PROTECT;
  endproperty
  a_limit: assert property (p_limit) else $error("table limit not enforced");

  property p_accessed;
    @(posedge clock) disable iff (!rst_b)
    accessed_wr |-> accessed_access[0] && exc_vector == sdc_pkg::EXC_NONE;
  endproperty
  a_accessed: assert property (p_accessed) else $error("accessed bit not set");

  property p_table_priv;
    @(posedge clock) disable iff (!rst_b)
    (req_valid && req_op == sdc_pkg::SDC_OP_LOAD_GLOBAL
      && current_priv_level != sdc_pkg::PRIV_TOP)
      |=> exc_vector == sdc_pkg::EXC_PROTECT && $stable(global_table);
  endproperty
  a_table_priv: assert property (p_table_priv) else $error("privileged table load");

  property p_int_gate_if;
    @(posedge clock) disable iff (!rst_b)
    (done && gate_kind == sdc_pkg::SDC_GATE_INT && exc_vector == sdc_pkg::EXC_NONE)
      |-> !if_out;
  endproperty
  a_int_gate_if: assert property (p_int_gate_if) else $error("interrupt gate kept enable");

  property p_trap_if;
    @(posedge clock) disable iff (!rst_b)
    (req_valid && req_op == sdc_pkg::SDC_OP_GATE && sys_type == sdc_pkg::TYP_TRAP_GATE)
      |=> if_out == $past(if_in);
  endproperty
  a_trap_if: assert property (p_trap_if) else $error("trap gate changed IF");

  property p_word_count;
    @(posedge clock) disable iff (!rst_b)
    (done && gate_kind != sdc_pkg::SDC_GATE_CALL) |-> copy_words == 5'h00;
  endproperty
  a_word_count: assert property (p_word_count) else $error("word count leaked");

  property p_ro_write;
    @(posedge clock) disable iff (!rst_b)
    (req_valid && req_op == sdc_pkg::SDC_OP_ACCESS && req_write && cache[req_seg].valid
      && !cache[req_seg].access[sdc_pkg::ACC_RW])
      |=> exc_vector == sdc_pkg::EXC_PROTECT;
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write allowed");
endmodule
`default_nettype wire

// >>> tb/sdc_table_model.sv
// descriptor table model: memory-resident entries served combinationally.
// assumes table bases keep address bits 6:3 as the entry number.
`timescale 1ns/1ns
`default_nettype none
module sdc_table_model (
  input wire logic [23:0] desc_addr,
  output sdc_pkg::sdc_desc_t req_desc,
  output sdc_pkg::sdc_desc_t gate_target
);
  // sixteen entries, filled by the bench; higher entries alias lower ones
  sdc_pkg::sdc_desc_t mem [16];
  // fetch the entry and the descriptor its gate selector names
  always_comb begin
    req_desc = mem[desc_addr[6:3]];
    gate_target = mem[req_desc.dest_sel[6:3]];
  end
endmodule
`default_nettype wire

// >>> tb/segment_descriptor_checker_bench.sv
// bench for the descriptor checker: drives requests at falling edges.
// assumes the table model answers in the request cycle.
`timescale 1ns/1ns
`default_nettype none
module segment_descriptor_checker_bench;
  logic clock = 1'h0, rst_b = 1'h0, req_valid = 1'h0, req_from_int = 1'h0;
  logic req_write = 1'h0, req_exec = 1'h0, priv_change = 1'h0, if_in = 1'h1;
  sdc_pkg::sdc_op_t req_op = sdc_pkg::SDC_OP_NONE;
  logic [1:0] req_seg = 2'h0, current_priv_level;
  logic [15:0] req_sel = 16'h0000, req_offset = 16'h0000, target_sel, target_offset;
  logic [7:0] req_vector = 8'h00, exc_vector, accessed_access;
  sdc_pkg::sdc_table_t req_table = '0, global_table, local_table, interrupt_table;
  sdc_pkg::sdc_desc_t req_desc, gate_target;
  sdc_pkg::sdc_gate_t gate_kind;
  logic [23:0] desc_addr;
  logic done, accessed_wr, if_out;
  logic [4:0] copy_words;
  int bad_count = 0, comparisons = 0;
  logic [7:0] exp_q [$]; // expected exception per request, oldest first

  sdc_table_model u_sdc_table_model (.desc_addr(desc_addr), .req_desc(req_desc),
    .gate_target(gate_target));
  sdc_checker u_sdc_checker (.clock(clock), .rst_b(rst_b), .req_valid(req_valid),
    .req_op(req_op), .req_seg(req_seg), .req_sel(req_sel), .req_vector(req_vector),
    .req_from_int(req_from_int), .req_write(req_write), .req_exec(req_exec),
    .req_offset(req_offset), .priv_change(priv_change), .req_desc(req_desc),
    .gate_target(gate_target), .req_table(req_table), .if_in(if_in),
    .desc_addr(desc_addr), .done(done), .exc_vector(exc_vector),
    .accessed_access(accessed_access), .accessed_wr(accessed_wr), .if_out(if_out),
    .copy_words(copy_words), .target_sel(target_sel), .target_offset(target_offset),
    .gate_kind(gate_kind), .current_priv_level(current_priv_level),
    .global_table(global_table), .local_table(local_table),
    .interrupt_table(interrupt_table));

  // 125 MHz clock
  initial begin
    forever #4 clock = ~clock;
  end

  task automatic chk(input string name, input logic [39:0] seen, input logic [39:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // one request held for one edge; returns in the cycle where done stands
  task automatic op(input sdc_pkg::sdc_op_t o, input logic [15:0] sel, input logic [7:0] e);
    @(negedge clock);
    req_op = o;
    req_sel = sel;
    req_valid = 1'h1;
    exp_q.push_back(e);
    @(negedge clock);
    req_valid = 1'h0;
  endtask

  // each done takes the oldest expectation; exc_vector stands only this cycle
  always @(negedge clock) begin
    if (done === 1'h1) begin
      if (exp_q.size() == 0) chk("spurious done", 40'h1, 40'h0);
      else chk("exc_vector", exc_vector, exp_q.pop_front());
    end
  end

  // hang guard
  initial begin
    #400000;
    chk("timeout", 40'h1, 40'h0);
    summarize();
  end

  initial begin
    void'($urandom(32'h2da99755));
    u_sdc_table_model.mem = '{default: '0};
    u_sdc_table_model.mem[1] = '{8'h92, 24'h010000, 16'h00ff, 16'h0000, 5'h00};
    u_sdc_table_model.mem[2] = '{8'h90, 24'h020000, 16'h00ff, 16'h0000, 5'h00};
    u_sdc_table_model.mem[3] = '{8'h96, 24'h030000, 16'h0100, 16'h0000, 5'h00};
    u_sdc_table_model.mem[4] = '{8'h12, 24'h040000, 16'h00ff, 16'h0000, 5'h00};
    u_sdc_table_model.mem[5] = '{8'h81, 24'h050000, 16'h002b, 16'h0000, 5'h00};
    u_sdc_table_model.mem[6] = '{8'h98, 24'h060000, 16'h00ff, 16'h0000, 5'h00};
    u_sdc_table_model.mem[7] = '{8'h86, 24'h000000, 16'h1234, 16'h0078, 5'h00};
    u_sdc_table_model.mem[8] = '{8'h87, 24'h000000, 16'h5678, 16'h0078, 5'h00};
    u_sdc_table_model.mem[9] = '{8'h84, 24'h000000, 16'h0040, 16'h0078, 5'h05};
    u_sdc_table_model.mem[10] = '{8'h86, 24'h000000, 16'h0040, 16'h0008, 5'h00};
    u_sdc_table_model.mem[11] = '{8'h06, 24'h000000, 16'h0040, 16'h0078, 5'h00};
    u_sdc_table_model.mem[12] = '{8'h85, 24'h000000, 16'hbeef, 16'h0028, 5'h00};
    u_sdc_table_model.mem[13] = '{8'h82, 24'h000100, 16'h0017, 16'h0000, 5'h00};
    u_sdc_table_model.mem[15] = '{8'h9a, 24'h0f0000, 16'hffff, 16'h0000, 5'h00};
    repeat (12) @(negedge clock);
    rst_b = 1'h1;
    chk("idt limit", interrupt_table.limit, 40'h03ff);
    chk("cpl", current_priv_level, 40'h0);
    req_table = '{24'h000000, 16'h007f};
    op(sdc_pkg::SDC_OP_LOAD_GLOBAL, 16'h0000, 8'h00);
    chk("global_table", global_table, {24'h000000, 16'h007f});
    req_table = '{24'h000000, 16'h00ff};
    op(sdc_pkg::SDC_OP_LOAD_INT, 16'h0000, 8'h00);
    chk("interrupt_table", interrupt_table, {24'h000000, 16'h00ff});
    $display("test tables done");
    // data segment: load, accessed flag, limit boundary, a random offset
    req_seg = 2'h2;
    op(sdc_pkg::SDC_OP_LOAD_SEG, 16'h0008, 8'h00);
    chk("accessed", {accessed_wr, accessed_access}, 40'h193);
    req_write = 1'h1;
    req_offset = 16'($urandom_range(255));
    op(sdc_pkg::SDC_OP_ACCESS, 16'h0008, 8'h00);
    req_offset = 16'h0100;
    op(sdc_pkg::SDC_OP_ACCESS, 16'h0008, 8'h0d);
    op(sdc_pkg::SDC_OP_LOAD_SEG, 16'h0010, 8'h00);
    op(sdc_pkg::SDC_OP_ACCESS, 16'h0010, 8'h0d);
    req_write = 1'h0;
    op(sdc_pkg::SDC_OP_ACCESS, 16'h0010, 8'h0d);
    req_offset = 16'h0080;
    op(sdc_pkg::SDC_OP_ACCESS, 16'h0010, 8'h00);
    op(sdc_pkg::SDC_OP_LOAD_SEG, 16'h0018, 8'h00);
    req_offset = 16'h0100;
    op(sdc_pkg::SDC_OP_ACCESS, 16'h0018, 8'h0d);
    // faulted loads must leave the grow-down entry cached
    op(sdc_pkg::SDC_OP_LOAD_SEG, 16'h0020, 8'h0b);
    op(sdc_pkg::SDC_OP_LOAD_SEG, 16'h0028, 8'h0d);
    op(sdc_pkg::SDC_OP_LOAD_SEG, 16'h00a0, 8'h0d);
    req_offset = 16'h0101;
    op(sdc_pkg::SDC_OP_ACCESS, 16'h0018, 8'h00);
    // execute-only code: reads refused
    req_seg = 2'h0;
    op(sdc_pkg::SDC_OP_LOAD_SEG, 16'h0030, 8'h00);
    op(sdc_pkg::SDC_OP_ACCESS, 16'h0030, 8'h0d);
    // selector test marks accessed but must not touch the code cache
    op(sdc_pkg::SDC_OP_TEST_SEL, 16'h0013, 8'h00);
    chk("test_sel", {accessed_wr, accessed_access, current_priv_level}, 40'h644);
    $display("test segments done");
    // local table through a global entry, then table_select picks it
    op(sdc_pkg::SDC_OP_LOAD_LOCAL, 16'h0068, 8'h00);
    chk("local_table", local_table, {24'h000100, 16'h0017});
    req_seg = 2'h3;
    op(sdc_pkg::SDC_OP_LOAD_SEG, 16'h001c, 8'h0d);
    op(sdc_pkg::SDC_OP_LOAD_SEG, 16'h0014, 8'h00);
    $display("test local done");
    // interrupt and trap gates through the interrupt table
    req_from_int = 1'h1;
    for (int i = 0; i < 2; i++) begin
      req_vector = 8'h07 + 8'(i);
      op(sdc_pkg::SDC_OP_GATE, 16'h0000, 8'h00);
      chk("if_out", if_out, 40'(i));
      chk("gate_kind", gate_kind, i ? sdc_pkg::SDC_GATE_TRAP : sdc_pkg::SDC_GATE_INT);
      chk("target_sel", target_sel, 40'h0078);
    end
    req_vector = 8'h0a;
    op(sdc_pkg::SDC_OP_GATE, 16'h0000, 8'h0d);
    req_vector = 8'h0b;
    op(sdc_pkg::SDC_OP_GATE, 16'h0000, 8'h0b);
    // a valid gate past the reloaded interrupt table limit
    req_vector = 8'h27;
    op(sdc_pkg::SDC_OP_GATE, 16'h0000, 8'h0d);
    // call, task and misplaced interrupt gates in the global table
    req_from_int = 1'h0;
    priv_change = 1'h1;
    op(sdc_pkg::SDC_OP_GATE, 16'h0048, 8'h00);
    chk("copy_words", {copy_words, target_offset}, {5'h05, 16'h0040});
    op(sdc_pkg::SDC_OP_GATE, 16'h0060, 8'h00);
    chk("task gate", {gate_kind, target_sel}, {sdc_pkg::SDC_GATE_TASK, 16'h0028});
    chk("task offset", target_offset, 40'h0);
    op(sdc_pkg::SDC_OP_GATE, 16'h0038, 8'h0d);
    // level 3 code: table loads refused, global table kept
    req_seg = 2'h0;
    op(sdc_pkg::SDC_OP_LOAD_SEG, 16'h0033, 8'h00);
    op(sdc_pkg::SDC_OP_LOAD_GLOBAL, 16'h0000, 8'h0d);
    op(sdc_pkg::SDC_OP_LOAD_LOCAL, 16'h0068, 8'h0d);
    chk("cpl", current_priv_level, 40'h3);
    chk("global_table", global_table, {24'h000000, 16'h007f});
    $display("test gates done");
    for (int i = 0; i < 10 && exp_q.size() != 0; i++) @(negedge clock);
    chk("pending answers", 40'(exp_q.size()), 40'h0);
    summarize();
  end
endmodule
`default_nettype wire
